// ---- sfc_regs.svh ----
/*
  Constants of the serial flash command front end: opcodes, byte counts,
  address width and link timing.
  Assumes a 25 MHz system clock on both ends and an SPI link in mode 0 or 3.
*/
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

`define SFC_BYTE_W 8
`define SFC_ADDR_BYTES 3
`define SFC_ADDR_USED_BITS 20
`define SFC_DUMMY_FAST 2
`define SFC_DUMMY_STD 1
`define SFC_DUMMY_OTP 2
`define SFC_ID_MAX_BYTES 4

`define SFC_CLK_NS 40
`define SFC_SCK_HALF_NS 160
`define SFC_SCK_HALF_CYC ((`SFC_SCK_HALF_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_LOW_FREQ_READ_MAX_CLOCK_MHZ 50

`define SFC_OP_READ_FAST 8'h1B
`define SFC_OP_READ_STD 8'h0B
`define SFC_OP_READ_SLOW 8'h03
`define SFC_OP_READ_DUAL 8'h3B
`define SFC_OP_ERASE_4K 8'h20
`define SFC_OP_ERASE_32K 8'h52
`define SFC_OP_ERASE_64K 8'hD8
`define SFC_OP_CHIP_ERASE_A 8'h60
`define SFC_OP_CHIP_ERASE_B 8'hC7
`define SFC_OP_PROG 8'h02
`define SFC_OP_PROG_DUAL 8'hA2
`define SFC_OP_WR_EN 8'h06
`define SFC_OP_WR_DIS 8'h04
`define SFC_OP_PROTECT 8'h36
`define SFC_OP_UNPROTECT 8'h39
`define SFC_OP_RD_PROT 8'h3C
`define SFC_OP_LOCKDOWN 8'h33
`define SFC_OP_FREEZE 8'h34
`define SFC_OP_RD_LOCK 8'h35
`define SFC_OP_OTP_PROG 8'h9B
`define SFC_OP_OTP_READ 8'h77
`define SFC_OP_RD_STATUS 8'h05
`define SFC_OP_WR_STATUS1 8'h01
`define SFC_OP_WR_STATUS2 8'h31
`define SFC_OP_RESET 8'hF0
`define SFC_OP_RD_ID 8'h9F
`define SFC_OP_DEEP_PD 8'hB9
`define SFC_OP_RESUME 8'hAB

`endif

// ---- sfc_pkg.sv ----
/*
  Types and the opcode decoder shared by both ends of the link.
  Assumes sfc_regs.svh is on the include path.
*/
`default_nettype none
`include "sfc_regs.svh"
package sfc_pkg;

  // ==========================================================
  // Types
  typedef logic [`SFC_BYTE_W-1:0] sfc_byte_t;
  typedef enum logic [1:0] {SFC_DIR_NONE = 2'h0, SFC_DIR_IN = 2'h1, SFC_DIR_OUT = 2'h2} sfc_dir_t;
  typedef struct packed {
    logic ok;
    logic has_addr;
    logic [1:0] ndummy;
    sfc_dir_t dir;
  } sfc_cmd_t;
  typedef enum logic [2:0] {
    SFC_ST_IDLE = 3'h0, SFC_ST_OPC = 3'h1, SFC_ST_ADDR = 3'h3, SFC_ST_DUMMY = 3'h2,
    SFC_ST_DOUT = 3'h6, SFC_ST_DIN = 3'h7, SFC_ST_SKIP = 3'h5
  } sfc_dev_state_t;
  typedef enum logic [2:0] {
    SFC_H_IDLE = 3'h0, SFC_H_LOW = 3'h1, SFC_H_HIGH = 3'h3, SFC_H_END = 3'h2, SFC_H_GAP = 3'h6
  } sfc_host_state_t;

  // ==========================================================
  // Opcode decoder: shape of the header and direction of data
  function automatic sfc_cmd_t sfc_decode(input sfc_byte_t op);
    sfc_cmd_t c;
    c = '{ok: 1'b1, has_addr: 1'b0, ndummy: 2'h0, dir: SFC_DIR_NONE};
    case (op)
      `SFC_OP_READ_FAST, `SFC_OP_OTP_READ: begin
        c.has_addr = 1'b1;
        c.ndummy = 2'(`SFC_DUMMY_FAST);
        c.dir = SFC_DIR_OUT;
      end
      `SFC_OP_READ_STD, `SFC_OP_READ_DUAL: begin
        c.has_addr = 1'b1;
        c.ndummy = 2'(`SFC_DUMMY_STD);
        c.dir = SFC_DIR_OUT;
      end
      `SFC_OP_READ_SLOW, `SFC_OP_RD_PROT, `SFC_OP_RD_LOCK: begin
        c.has_addr = 1'b1;
        c.dir = SFC_DIR_OUT;
      end
      `SFC_OP_ERASE_4K, `SFC_OP_ERASE_32K, `SFC_OP_ERASE_64K, `SFC_OP_PROTECT, `SFC_OP_UNPROTECT: begin
        c.has_addr = 1'b1;
      end
      `SFC_OP_PROG, `SFC_OP_PROG_DUAL, `SFC_OP_LOCKDOWN, `SFC_OP_FREEZE, `SFC_OP_OTP_PROG: begin
        c.has_addr = 1'b1;
        c.dir = SFC_DIR_IN;
      end
      `SFC_OP_RD_STATUS, `SFC_OP_RD_ID: begin
        c.dir = SFC_DIR_OUT;
      end
      `SFC_OP_WR_STATUS1, `SFC_OP_WR_STATUS2, `SFC_OP_RESET: begin
        c.dir = SFC_DIR_IN;
      end
      `SFC_OP_CHIP_ERASE_A, `SFC_OP_CHIP_ERASE_B, `SFC_OP_WR_EN, `SFC_OP_WR_DIS,
      `SFC_OP_DEEP_PD, `SFC_OP_RESUME: begin
        c.dir = SFC_DIR_NONE;
      end
      default: begin
        c.ok = 1'b0;
      end
    endcase
    return c;
  endfunction

endpackage
`default_nettype wire

// ---- sfc_link_if.sv ----
/*
  The four-wire serial link between the host end and the flash end.
  Assumes one end per modport; the output line is modelled with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  // ==========================================================
  // Wire level: undriven output line floats to a pulled-up one
  assign so_line = so_oe ? so : 1'b1;

  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so_line);
endinterface
`default_nettype wire

// ---- sfc_host.sv ----
/*
  Host end: an SPI mode 0 master that frames one command per request.
  Assumes requests come from logic on clk and the flash end decodes like sfc_decode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_host #(
  parameter int HALF_CYC = `SFC_SCK_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  sfc_link_if.host link,
  input wire logic start,
  input wire sfc_pkg::sfc_byte_t op,
  input wire logic [23:0] addr,
  input wire logic [8:0] n_data,
  input wire sfc_pkg::sfc_byte_t wdata,
  output logic wdata_take_ff,
  output sfc_pkg::sfc_byte_t rdata_ff,
  output logic rdata_valid_ff,
  output logic busy_ff
);
  import sfc_pkg::*;

  sfc_host_state_t state_ff;
  sfc_cmd_t cmd_ff;
  logic [7:0] cnt_ff;
  logic [2:0] bit_ff;
  logic [9:0] idx_ff;
  logic [9:0] hdr_ff;
  logic [9:0] tot_ff;
  logic [23:0] addr_ff;
  logic [7:0] tx_ff;
  logic [6:0] rx_ff;
  logic so_m_ff;
  logic so_s_ff;
  logic cs_n_ff;
  logic sck_ff;
  logic si_ff;
  logic half_done;
  logic [9:0] nxt_idx;
  sfc_byte_t nxt_tx;
  sfc_cmd_t dec;

  assign link.cs_n = cs_n_ff;
  assign link.sck = sck_ff;
  assign link.si = si_ff;
  assign half_done = (cnt_ff == 8'(HALF_CYC - 1));
  assign nxt_idx = idx_ff + 10'h001;
  assign dec = sfc_decode(op);

  // ==========================================================
  // Output line synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      so_m_ff <= 1'b1;
      so_s_ff <= 1'b1;
    end else begin
      so_m_ff <= link.so_line;
      so_s_ff <= so_m_ff;
    end
  end

  // ==========================================================
  // Byte to send next: opcode, address, dummy, then data
  always_comb begin
    nxt_tx = 8'h00;
    if (cmd_ff.has_addr && nxt_idx == 10'h001) begin
      nxt_tx = addr_ff[23:16];
    end else if (cmd_ff.has_addr && nxt_idx == 10'h002) begin
      nxt_tx = addr_ff[15:8];
    end else if (cmd_ff.has_addr && nxt_idx == 10'h003) begin
      nxt_tx = addr_ff[7:0];
    end else if (nxt_idx >= hdr_ff && cmd_ff.dir == SFC_DIR_IN) begin
      nxt_tx = wdata;
    end
  end

  // ==========================================================
  // Framing sequencer; the clock is a divider of clk, idle low (mode 0)
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= SFC_H_IDLE;
      cmd_ff <= '0;
      cnt_ff <= 8'h00;
      bit_ff <= 3'h0;
      idx_ff <= 10'h000;
      hdr_ff <= 10'h000;
      tot_ff <= 10'h000;
      addr_ff <= 24'h000000;
      tx_ff <= 8'h00;
      rx_ff <= 7'h00;
      cs_n_ff <= 1'b1;
      sck_ff <= 1'b0;
      si_ff <= 1'b0;
      busy_ff <= 1'b0;
      wdata_take_ff <= 1'b0;
      rdata_ff <= 8'h00;
      rdata_valid_ff <= 1'b0;
    end else begin
      wdata_take_ff <= 1'b0;
      rdata_valid_ff <= 1'b0;
      cnt_ff <= half_done ? 8'h00 : cnt_ff + 8'h01;
      case (state_ff)
        SFC_H_IDLE: begin
          cnt_ff <= 8'h00;
          if (start) begin
            // Chip select first, opcode MSB already on the line
            state_ff <= SFC_H_LOW;
            cmd_ff <= dec;
            addr_ff <= addr;
            hdr_ff <= 10'(1 + (dec.has_addr ? `SFC_ADDR_BYTES : 0) + int'(dec.ndummy));
            tot_ff <= 10'(1 + (dec.has_addr ? `SFC_ADDR_BYTES : 0) + int'(dec.ndummy) + int'(n_data));
            idx_ff <= 10'h000;
            bit_ff <= 3'h0;
            tx_ff <= op;
            si_ff <= op[7];
            cs_n_ff <= 1'b0;
            busy_ff <= 1'b1;
          end
        end
        SFC_H_LOW: begin
          if (half_done) begin
            sck_ff <= 1'b1;
            state_ff <= SFC_H_HIGH;
          end
        end
        SFC_H_HIGH: begin
          if (half_done) begin
            // Sample late in the high phase: the flash answer crosses two synchronisers
            sck_ff <= 1'b0;
            rx_ff <= {rx_ff[5:0], so_s_ff};
            bit_ff <= bit_ff + 3'h1;
            state_ff <= SFC_H_LOW;
            si_ff <= tx_ff[6];
            tx_ff <= {tx_ff[6:0], 1'b0};
            if (bit_ff == 3'h7) begin
              if (idx_ff >= hdr_ff && cmd_ff.dir == SFC_DIR_OUT) begin
                rdata_ff <= {rx_ff, so_s_ff};
                rdata_valid_ff <= 1'b1;
              end
              if (nxt_idx == tot_ff) begin
                state_ff <= SFC_H_END;
              end else begin
                idx_ff <= nxt_idx;
                tx_ff <= nxt_tx;
                si_ff <= nxt_tx[7];
                wdata_take_ff <= (nxt_idx >= hdr_ff && cmd_ff.dir == SFC_DIR_IN);
              end
            end
          end
        end
        SFC_H_END: begin
          if (half_done) begin
            cs_n_ff <= 1'b1;
            state_ff <= SFC_H_GAP;
          end
        end
        SFC_H_GAP: begin
          if (half_done) begin
            busy_ff <= 1'b0;
            state_ff <= SFC_H_IDLE;
          end
        end
        default: begin
          state_ff <= SFC_H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- sfc_dev.sv ----
/*
  Flash end: command front end that frames, decodes and streams array reads.
  Assumes the link pins are asynchronous to clk and the link clock is far slower than
  clk (at least eight clk periods per link clock period); array bytes come from a
  memory on clk that answers mem_addr_ff within two clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfc_regs.svh"
module sfc_dev #(
  parameter int ADDR_W = `SFC_ADDR_USED_BITS
) (
  input wire logic clk,
  input wire logic rst,
  sfc_link_if.dev link,
  output logic [ADDR_W-1:0] mem_addr_ff,
  input wire sfc_pkg::sfc_byte_t mem_data,
  output logic rd_take_ff,
  output sfc_pkg::sfc_byte_t wr_data_ff,
  output logic wr_valid_ff,
  output logic cmd_go_ff,
  output sfc_pkg::sfc_byte_t cmd_op_ff,
  output logic [ADDR_W-1:0] cmd_addr_ff,
  output logic cmd_drop_ff
);
  import sfc_pkg::*;

  // ==========================================================
  // Declarations
  logic sck_m_ff;
  logic sck_s_ff;
  logic sck_d_ff;
  logic cs_m_ff;
  logic cs_s_ff;
  logic cs_d_ff;
  logic si_m_ff;
  logic si_s_ff;
  sfc_dev_state_t state_ff;
  sfc_dev_state_t nxt_state;
  sfc_cmd_t cmd_ff;
  sfc_cmd_t dec;
  sfc_byte_t op_ff;
  logic [6:0] in_sh_ff;
  logic [6:0] out_sh_ff;
  logic [2:0] bit_ff;
  logic [1:0] byte_ff;
  logic [1:0] dum_ff;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic so_ff;
  logic so_oe_ff;
  logic sck_rise;
  logic sck_fall;
  logic cs_lo;
  logic cs_rise;
  logic byte_end;
  logic hdr_ok;
  sfc_byte_t rx_byte;

  assign link.so = so_ff;
  assign link.so_oe = so_oe_ff;

  // ==========================================================
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_m_ff <= 1'b0;
      sck_s_ff <= 1'b0;
      sck_d_ff <= 1'b0;
      cs_m_ff <= 1'b1;
      cs_s_ff <= 1'b1;
      cs_d_ff <= 1'b1;
      si_m_ff <= 1'b0;
      si_s_ff <= 1'b0;
    end else begin
      sck_m_ff <= link.sck;
      sck_s_ff <= sck_m_ff;
      sck_d_ff <= sck_s_ff;
      cs_m_ff <= link.cs_n;
      cs_s_ff <= cs_m_ff;
      cs_d_ff <= cs_s_ff;
      si_m_ff <= link.si;
      si_s_ff <= si_m_ff;
    end
  end

  // Edge finders; input and clock share the same sync delay, so sampling holds
  assign sck_rise = sck_s_ff & ~sck_d_ff;
  assign sck_fall = ~sck_s_ff & sck_d_ff;
  assign cs_lo = ~cs_s_ff;
  assign cs_rise = cs_s_ff & ~cs_d_ff;
  assign rx_byte = {in_sh_ff, si_s_ff};
  assign byte_end = sck_rise && (bit_ff == 3'h7);
  assign dec = sfc_decode(rx_byte);

  // A header is complete once the data phase, or the tail of a dataless command, is reached
  assign hdr_ok = (state_ff == SFC_ST_DIN) || (state_ff == SFC_ST_DOUT) ||
                  (state_ff == SFC_ST_SKIP && cmd_ff.ok);

  // ==========================================================
  // Bit counter and input shifter
  // Receive phases count rising edges; the read phase counts falling ones
  always_ff @(posedge clk) begin
    if (rst || !cs_lo) begin
      bit_ff <= 3'h0;
      in_sh_ff <= 7'h00;
    end else if (state_ff == SFC_ST_DOUT) begin
      if (sck_fall) begin
        bit_ff <= bit_ff + 3'h1;
      end
    end else if (sck_rise) begin
      bit_ff <= bit_ff + 3'h1;
      in_sh_ff <= {in_sh_ff[5:0], si_s_ff};
    end
  end

  // ==========================================================
  // Next phase of the transaction
  always_comb begin
    nxt_state = state_ff;
    if (!cs_lo) begin
      nxt_state = SFC_ST_IDLE;
    end else begin
      case (state_ff)
        SFC_ST_IDLE: begin
          nxt_state = SFC_ST_OPC;
        end
        SFC_ST_OPC: begin
          if (byte_end) begin
            if (!dec.ok) begin
              nxt_state = SFC_ST_SKIP;
            end else if (dec.has_addr) begin
              nxt_state = SFC_ST_ADDR;
            end else if (dec.dir == SFC_DIR_OUT) begin
              nxt_state = SFC_ST_DOUT;
            end else if (dec.dir == SFC_DIR_IN) begin
              nxt_state = SFC_ST_DIN;
            end else begin
              nxt_state = SFC_ST_SKIP;
            end
          end
        end
        SFC_ST_ADDR: begin
          if (byte_end && byte_ff == 2'(`SFC_ADDR_BYTES - 1)) begin
            if (cmd_ff.ndummy != 2'h0) begin
              nxt_state = SFC_ST_DUMMY;
            end else if (cmd_ff.dir == SFC_DIR_OUT) begin
              nxt_state = SFC_ST_DOUT;
            end else if (cmd_ff.dir == SFC_DIR_IN) begin
              nxt_state = SFC_ST_DIN;
            end else begin
              nxt_state = SFC_ST_SKIP;
            end
          end
        end
        SFC_ST_DUMMY: begin
          if (byte_end && dum_ff == 2'h1) begin
            nxt_state = (cmd_ff.dir == SFC_DIR_OUT) ? SFC_ST_DOUT : SFC_ST_DIN;
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= SFC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Opcode, header counters and address collection
  assign nxt_addr = (state_ff == SFC_ST_ADDR && byte_end) ? {addr_ff[15:0], rx_byte} : addr_ff;

  always_ff @(posedge clk) begin
    if (rst || !cs_lo) begin
      cmd_ff <= '0;
      op_ff <= 8'h00;
      byte_ff <= 2'h0;
      dum_ff <= 2'h0;
      addr_ff <= 24'h000000;
    end else begin
      addr_ff <= nxt_addr;
      if (state_ff == SFC_ST_OPC && byte_end) begin
        cmd_ff <= dec;
        op_ff <= rx_byte;
      end
      if (state_ff == SFC_ST_ADDR && byte_end) begin
        byte_ff <= byte_ff + 2'h1;
        dum_ff <= cmd_ff.ndummy;
      end
      if (state_ff == SFC_ST_DUMMY && byte_end) begin
        dum_ff <= dum_ff - 2'h1;
      end
    end
  end

  // ==========================================================
  // Read address counter; the top address bits are simply not kept
  // A counter of ADDR_W bits rolls from all ones to zero with no extra cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_addr_ff <= '0;
      rd_take_ff <= 1'b0;
    end else begin
      rd_take_ff <= 1'b0;
      if (nxt_state == SFC_ST_DOUT && state_ff != SFC_ST_DOUT) begin
        mem_addr_ff <= nxt_addr[ADDR_W-1:0];
      end else if (state_ff == SFC_ST_DOUT && cs_lo && sck_fall && bit_ff == 3'h0) begin
        mem_addr_ff <= mem_addr_ff + ADDR_W'(1);
        rd_take_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Output shifter: new bit on each falling edge, MSB of each byte first
  always_ff @(posedge clk) begin
    if (rst) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
      out_sh_ff <= 7'h00;
    end else if (!cs_lo) begin
      so_oe_ff <= 1'b0;
    end else if (state_ff == SFC_ST_DOUT && sck_fall) begin
      so_oe_ff <= 1'b1;
      if (bit_ff == 3'h0) begin
        so_ff <= mem_data[7];
        out_sh_ff <= mem_data[6:0];
      end else begin
        so_ff <= out_sh_ff[6];
        out_sh_ff <= {out_sh_ff[5:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Incoming data bytes for program, lockdown and status writes
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_valid_ff <= 1'b0;
      wr_data_ff <= 8'h00;
    end else begin
      wr_valid_ff <= 1'b0;
      if (state_ff == SFC_ST_DIN && cs_lo && byte_end) begin
        wr_valid_ff <= 1'b1;
        wr_data_ff <= rx_byte;
      end
    end
  end

  // ==========================================================
  // End of frame: hand a complete command on, or report a dropped one
  // A partial byte after a complete header still counts; the back end judges alignment
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_go_ff <= 1'b0;
      cmd_drop_ff <= 1'b0;
      cmd_op_ff <= 8'h00;
      cmd_addr_ff <= '0;
    end else begin
      cmd_go_ff <= cs_rise && hdr_ok;
      cmd_drop_ff <= cs_rise && !hdr_ok && state_ff != SFC_ST_IDLE;
      if (cs_rise && hdr_ok) begin
        cmd_op_ff <= op_ff;
        cmd_addr_ff <= addr_ff[ADDR_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// ---- sfc_link_props.sv ----
/*
  Checker for the link between the host end and the flash end.
  Assumes the host runs with a half period of four clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sfc_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic so_line
);
  logic sck_q_ff;
  logic [11:0] rises_ff;

  // ==========================================================
  // Helpers
  // Count link clock rises in the frame; deselect clears it
  always_ff @(posedge clk) begin
    sck_q_ff <= sck;
    if (rst || cs_n) begin
      rises_ff <= 12'h000;
    end else if (sck && !sck_q_ff) begin
      rises_ff <= rises_ff + 12'h001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Wire rules
  a_sck_idle_low: assert property (cs_n |-> !sck)
    else $error("sck high while deselected");
  a_sck_high_len: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
    else $error("sck high phase not four cycles");
  a_si_on_low: assert property (!$stable(si) |-> !sck)
    else $error("si moved while sck high");
  a_so_on_low: assert property (sck && $past(sck) |-> $stable(so))
    else $error("so moved while sck high");
  a_whole_bytes: assert property ($rose(cs_n) |-> rises_ff[2:0] == 3'h0)
    else $error("frame not whole bytes");
  a_data_after_hdr: assert property ($rose(so_oe) |-> !cs_n && rises_ff >= 12'h008 && rises_ff[2:0] == 3'h0)
    else $error("so driven before header end");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("so still driven after deselect");
  a_idle_line: assert property (cs_n [*6] |-> !so_oe && so_line)
    else $error("so line not released");
endmodule
`default_nettype wire

// ---- sfc_tb.sv ----
/*
  Bench: host end and flash end joined, plus a second flash end
  driven by hand to break framing.
  Assumes a half period of four clk cycles on the host.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  sfc_byte_t op = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [8:0] n_data = 9'h000;
  sfc_byte_t wdata, rdata, wr_data, cmd_op;
  sfc_byte_t mem_data = 8'h00;
  logic wtake, rvalid, busy, wvalid, go, drop, go2, drop2, take;
  logic [19:0] mem_addr, cmd_addr;
  logic [1:0] widx = 2'h0;
  sfc_byte_t wbuf [4] = '{8'hC3, 8'h5A, 8'h81, 8'h7E};
  sfc_byte_t rd_ops [7] = '{8'h1B, 8'h0B, 8'h03, 8'h3B, 8'h77, 8'h3C, 8'h35};
  sfc_byte_t wa_ops [5] = '{8'h02, 8'hA2, 8'h33, 8'h34, 8'h9B};
  sfc_byte_t er_ops [5] = '{8'h20, 8'h52, 8'hD8, 8'h36, 8'h39};
  sfc_byte_t nd_ops [6] = '{8'h60, 8'hC7, 8'h06, 8'h04, 8'hB9, 8'hAB};
  sfc_byte_t rq [$];
  sfc_byte_t wq [$];
  int go_n = 0, drop_n = 0, oe_n = 0, go2_n = 0, drop2_n = 0, oe2_n = 0, tk_n = 0;
  int miscompares = 0, checks = 0;

  sfc_link_if link ();
  sfc_link_if link2 ();
  sfc_host #(.HALF_CYC(4)) sfc_host_inst (.clk(clk), .rst(rst), .link(link.host), .start(start), .op(op),
    .addr(addr), .n_data(n_data), .wdata(wdata), .wdata_take_ff(wtake), .rdata_ff(rdata),
    .rdata_valid_ff(rvalid), .busy_ff(busy));
  sfc_dev sfc_dev_inst (.clk(clk), .rst(rst), .link(link.dev), .mem_addr_ff(mem_addr), .mem_data(mem_data),
    .rd_take_ff(take), .wr_data_ff(wr_data), .wr_valid_ff(wvalid), .cmd_go_ff(go), .cmd_op_ff(cmd_op),
    .cmd_addr_ff(cmd_addr), .cmd_drop_ff(drop));
  sfc_dev sfc_dev_inst_b (.clk(clk), .rst(rst), .link(link2.dev), .mem_addr_ff(), .mem_data(8'h00),
    .rd_take_ff(), .wr_data_ff(), .wr_valid_ff(), .cmd_go_ff(go2), .cmd_op_ff(), .cmd_addr_ff(),
    .cmd_drop_ff(drop2));
  sfc_link_props sfc_link_props_inst (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .so(link.so), .so_oe(link.so_oe), .so_line(link.so_line));

  // ==========================================================
  // Clock, array model and capture
  always #20 clk = ~clk;
  assign wdata = wbuf[widx];

  // Array answers one cycle after its address moves, inside the two allowed
  always @(posedge clk) begin
    mem_data <= exp_byte(mem_addr);
    if (wtake) widx <= widx + 2'h1;
    if (rvalid) rq.push_back(rdata);
    if (wvalid) wq.push_back(wr_data);
    go_n += go;
    drop_n += drop;
    tk_n += take;
    oe_n += link.so_oe;
    go2_n += go2;
    drop2_n += drop2;
    oe2_n += link2.so_oe;
  end

  // ==========================================================
  // Tasks
  function automatic sfc_byte_t exp_byte(input logic [19:0] a);
    return a[7:0] + a[19:12] + 8'h11;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Kind: 0 no data, 1 write, 2 read from base, 3 refused opcode
  task automatic run(input sfc_byte_t o, input logic [23:0] a, input int n, input int kind,
                     input logic [19:0] base);
    int g, d, e, b, i, t;
    g = go_n;
    d = drop_n;
    e = oe_n;
    t = tk_n;
    b = widx;
    rq.delete();
    wq.delete();
    op <= o;
    addr <= a;
    n_data <= 9'(n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
    repeat (8) @(posedge clk);
    if (kind == 3) begin
      chk("drop", drop_n - d, 1);
      chk("go", go_n - g, 0);
      chk("drive", oe_n - e, 0);
      chk("wr", wq.size(), 0);
      chk("take", tk_n - t, 0);
    end else begin
      chk("go", go_n - g, 1);
      chk("op", cmd_op, o);
      if (a != 0) chk("addr", cmd_addr, a[19:0]);
      chk("wr", wq.size(), kind == 1 ? n : 0);
      chk("rd", rq.size(), kind == 2 ? n : 0);
      chk("take", tk_n - t, kind == 2 ? n + 1 : 0);
      foreach (wq[k]) chk("wbyte", wq[k], wbuf[2'(b + k)]);
      foreach (rq[k]) chk("rbyte", rq[k], exp_byte(base + 20'(k)));
    end
  endtask

  // Hand-driven frame on the second link, mode 0, whole bits only
  task automatic bang(input logic [39:0] bits, input int n);
    link2.cs_n <= 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      link2.si <= bits[k];
      repeat (4) @(posedge clk);
      link2.sck <= 1'b1;
      repeat (4) @(posedge clk);
      link2.sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link2.cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    link2.cs_n = 1'b1;
    link2.sck = 1'b0;
    link2.si = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    run(8'h03, 24'hAFFFFE, 3, 2, 20'hFFFFE);
    foreach (rd_ops[i]) run(rd_ops[i], 24'h012345, 2, 2, 20'h12345);
    run(8'h05, 24'h0, 4, 2, 20'h0);
    run(8'h9F, 24'h0, 4, 2, 20'h0);
    foreach (wa_ops[i]) run(wa_ops[i], 24'h0ABCDE, 1, 1, 20'h0);
    run(8'h02, 24'h0ABCDE, 3, 1, 20'h0);
    run(8'h01, 24'h0, 1, 1, 20'h0);
    run(8'h31, 24'h0, 1, 1, 20'h0);
    foreach (er_ops[i]) run(er_ops[i], 24'h054321, 0, 0, 20'h0);
    foreach (nd_ops[i]) run(nd_ops[i], 24'h0, 0, 0, 20'h0);
    run(8'hF0, 24'h0, 1, 1, 20'h0);
    run(8'h1B, 24'h0FFFFF, 2, 2, 20'hFFFFF);
    run(8'hFF, 24'h0, 2, 3, 20'h0);
    run(8'h00, 24'h0, 2, 3, 20'h0);
    bang(40'h0B1234, 24);
    chk("drop2", drop2_n, 1);
    chk("go2", go2_n, 0);
    bang(40'hFF03000000, 40);
    chk("drop2", drop2_n, 2);
    chk("drive2", oe2_n, 0);
    bang(40'h3001234A, 36);
    chk("go2", go2_n, 1);
    chk("drive2", oe2_n > 0, 1);
    chk("off2", link2.so_oe, 0);
    chk("line2", link2.so_line, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
